// ### core/rso_pkg.sv
`default_nettype none
package rso_pkg;

  // ---------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------
  localparam int FUNC_W = 6;      // Weights 1..32
  localparam int FAULT_W = 14;    // Weights 1..8192
  localparam int AREA_N = 15;     // Approach check areas
  localparam int ARM_N = 16;      // Arm selection inputs
  localparam int SYNC_N = 3;      // Pin synchroniser depth

  // ---------------------------------------------------------------------
  // Default bit positions of the status word
  // ---------------------------------------------------------------------
  localparam int BIT_READY = 0;
  localparam int BIT_RUNNING = 1;
  localparam int BIT_PAUSED = 2;
  localparam int BIT_ERROR = 3;
  localparam int BIT_ESTOP = 4;
  localparam int BIT_GUARD = 5;
  localparam int BIT_CRIT = 6;
  localparam int BIT_WARN = 7;
  localparam int STD_W = 8;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [ARM_N-1:0] ARM_SEL_RST = 16'hffff;  // All arms chosen
  localparam logic [STD_W-1:0] STD_RST = 8'h00;

  // Startup state machine
  typedef enum logic [1:0] {
    RSO_BOOT = 2'b00,
    RSO_UP = 2'b01
  } rso_boot_e;

  // Per-arm condition bundle from the arm control
  typedef struct packed {
    logic [ARM_N-1:0] motor;
    logic [ARM_N-1:0] home;
    logic [ARM_N-1:0] high_power;
    logic [ARM_N-1:0] uncal;
  } rso_arm_s;

  // Controller state bundle
  typedef struct packed {
    logic startup_done;
    logic task_running;
    logic task_paused;
    logic error_event;
    logic crit_event;
    logic warn_active;
    logic estop;
    logic guard_open;
    logic recover_wait;
    logic recover_run;
    logic cmd_busy;
    logic cmd_reject;
    logic remote_ok;
    logic teach;
    logic test;
    logic enable_sw;
    logic [FUNC_W-1:0] func_num;
    logic [FAULT_W-1:0] fault_num;
    logic [AREA_N-1:0] area;
  } rso_ctl_s;

  // Status output bundle
  typedef struct packed {
    logic [STD_W-1:0] std;
    logic motor_energized;
    logic home_position_flag;
    logic high_power_flag;
    logic calibration_needed;
    logic recover_pending;
    logic recover_active;
    logic command_executing;
    logic command_rejected;
    logic [FUNC_W-1:0] function_number;
    logic remote_accept_state;
    logic teach_state_flag;
    logic test_state_flag;
    logic enable_switch_flag;
    logic [FAULT_W-1:0] fault_number;
    logic [AREA_N-1:0] area_occupancy;
  } rso_out_s;

endpackage
`default_nettype wire

// ### core/rso_status_out.sv
`default_nettype none
module rso_status_out #(
  parameter int ARMS = rso_pkg::ARM_N
) (
  input wire logic clk,
  input wire logic rst,
  input wire rso_pkg::rso_ctl_s ctl,
  input wire rso_pkg::rso_arm_s arm,
  input wire logic [rso_pkg::ARM_N-1:0] arm_select_pin,
  input wire logic arm_select_strobe_pin,
  input wire logic reset_input_pin,
  output logic reset_accepted,
  output rso_pkg::rso_out_s status
);
  import rso_pkg::*;

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  logic [SYNC_N-1:0] rst_in_sync_reg;
  logic [SYNC_N-1:0] sel_stb_sync_reg;
  logic [ARM_N-1:0] sel_s1_reg, sel_s2_reg, sel_s3_reg;
  logic rst_in_reg, sel_stb_reg, sel_stb_d_reg;

  // Three stages; a reset or strobe change counts when stages two and three agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rst_in_sync_reg <= '0;
      sel_stb_sync_reg <= '0;
      sel_s1_reg <= '0;
      sel_s2_reg <= '0;
      sel_s3_reg <= '0;
    end
    else
    begin
      rst_in_sync_reg <= {rst_in_sync_reg[1:0], reset_input_pin};
      sel_stb_sync_reg <= {sel_stb_sync_reg[1:0], arm_select_strobe_pin};
      sel_s1_reg <= arm_select_pin;
      sel_s2_reg <= sel_s1_reg;
      sel_s3_reg <= sel_s2_reg;
    end
  end

  // Filtered levels: hold the old value while stages disagree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rst_in_reg <= 1'b0;
      sel_stb_reg <= 1'b0;
      sel_stb_d_reg <= 1'b0;
    end
    else
    begin
      if (rst_in_sync_reg[1] == rst_in_sync_reg[2])
        rst_in_reg <= rst_in_sync_reg[2];
      if (sel_stb_sync_reg[1] == sel_stb_sync_reg[2])
        sel_stb_reg <= sel_stb_sync_reg[2];
      sel_stb_d_reg <= sel_stb_reg;
    end
  end

  // ---------------------------------------------------------------------
  // Startup tracking
  // ---------------------------------------------------------------------
  rso_boot_e boot_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      boot_reg <= RSO_BOOT;
    else
    begin
      case (boot_reg)
        RSO_BOOT: if (ctl.startup_done) boot_reg <= RSO_UP;
        RSO_UP: boot_reg <= RSO_UP;
        default: boot_reg <= RSO_BOOT;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Arm selection
  // ---------------------------------------------------------------------
  logic [ARM_N-1:0] arm_sel_reg;
  logic sel_rise;
  logic sel_valid;

  assign sel_rise = sel_stb_reg && !sel_stb_d_reg;
  // Selection only taken in remote accept state
  assign sel_valid = sel_rise && status.remote_accept_state;

  // Kept until changed; a reboot (rst) returns to all arms
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      arm_sel_reg <= ARM_SEL_RST;
    else if (sel_valid && sel_s3_reg != '0)
      arm_sel_reg <= sel_s3_reg;
  end

  // Any selected arm meets the condition
  function automatic logic any_sel(input logic [ARM_N-1:0] cond,
                                   input logic [ARM_N-1:0] sel);
    any_sel = |(cond & sel);
  endfunction

  // ---------------------------------------------------------------------
  // Latched faults
  // ---------------------------------------------------------------------
  logic error_reg, crit_reg;
  logic clear_req;

  // Reset input only counts in remote accept state
  assign clear_req = rst_in_reg && status.remote_accept_state;
  assign reset_accepted = clear_req && !crit_reg;

  // New event wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      error_reg <= 1'b0;
    else if (ctl.error_event)
      error_reg <= 1'b1;
    else if (clear_req && !crit_reg)
      error_reg <= 1'b0;
  end

  // Only a reboot clears the critical flag; the reset input is ignored
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      crit_reg <= 1'b0;
    else if (ctl.crit_event)
      crit_reg <= 1'b1;
  end

  // ---------------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------------
  logic [STD_W-1:0] std_next;

  always_comb
  begin
    std_next = STD_RST;
    std_next[BIT_READY] = (boot_reg == RSO_UP) && !ctl.task_running;
    std_next[BIT_RUNNING] = ctl.task_running && !ctl.task_paused;
    std_next[BIT_PAUSED] = ctl.task_paused;
    std_next[BIT_ERROR] = error_reg;
    std_next[BIT_ESTOP] = ctl.estop;
    std_next[BIT_GUARD] = ctl.guard_open;
    std_next[BIT_CRIT] = crit_reg;
    std_next[BIT_WARN] = ctl.warn_active;
  end

  // All status outputs from one register stage so groups move together; reset_accepted is combinational
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      status <= '0;
    else
    begin
      status.std <= std_next;
      status.motor_energized <= any_sel(arm.motor, arm_sel_reg);
      status.home_position_flag <= any_sel(arm.home, arm_sel_reg);
      status.high_power_flag <= any_sel(arm.high_power, arm_sel_reg);
      status.calibration_needed <= any_sel(arm.uncal, arm_sel_reg);
      status.recover_pending <= ctl.recover_wait;
      status.recover_active <= ctl.recover_run;
      status.command_executing <= ctl.cmd_busy;
      status.command_rejected <= ctl.cmd_reject;
      status.function_number <= ctl.func_num;
      status.remote_accept_state <= ctl.remote_ok;
      status.teach_state_flag <= ctl.teach;
      status.test_state_flag <= ctl.test;
      status.enable_switch_flag <= ctl.enable_sw;
      status.fault_number <= ctl.fault_num;
      status.area_occupancy <= ctl.area;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_ready_follows: assert property (
    (boot_reg == RSO_UP && !ctl.task_running) |=> status.std[BIT_READY])
    else $error("ready not asserted");
  a_running_paused: assert property (
    status.std[BIT_RUNNING] |-> !status.std[BIT_PAUSED])
    else $error("running while paused");
  a_paused_follows: assert property (
    ctl.task_paused |=> status.std[BIT_PAUSED])
    else $error("paused missing");
  a_error_sticky: assert property (
    (ctl.error_event ##1 !clear_req) |=> status.std[BIT_ERROR])
    else $error("error not latched");
  a_estop_follows: assert property (
    ctl.estop |=> status.std[BIT_ESTOP])
    else $error("estop missing");
  a_guard_follows: assert property (
    $changed(ctl.guard_open) |=> status.std[BIT_GUARD] == $past(ctl.guard_open))
    else $error("guard flag wrong");
  a_crit_holds: assert property (
    status.std[BIT_CRIT] |=> status.std[BIT_CRIT])
    else $error("critical cleared");
  a_motor_select: assert property (
    |(arm.motor & arm_sel_reg) |=> status.motor_energized)
    else $error("motor flag wrong");
  a_numbers_track: assert property (
    1'b1 |=> status.function_number == $past(ctl.func_num)
         && status.fault_number == $past(ctl.fault_num))
    else $error("number group wrong");
  a_sel_gated: assert property (
    !status.remote_accept_state |=> $stable(arm_sel_reg))
    else $error("selection taken outside accept");
  a_area_track: assert property (
    1'b1 |=> status.area_occupancy == $past(ctl.area))
    else $error("area flags wrong");

  // Status word levels and their release
  a_ready_busy: assert property (
    ctl.task_running |=> !status.std[BIT_READY])
    else $error("ready while task runs");
  a_ready_boot: assert property (
    (boot_reg == RSO_BOOT) |=> !status.std[BIT_READY])
    else $error("ready before startup");
  a_boot_stays: assert property (
    (boot_reg == RSO_UP) |=> (boot_reg == RSO_UP))
    else $error("startup state lost");
  a_running_follows: assert property (
    (ctl.task_running && !ctl.task_paused) |=> status.std[BIT_RUNNING])
    else $error("running missing");
  a_running_idle: assert property (
    !ctl.task_running |=> !status.std[BIT_RUNNING])
    else $error("running without task");
  a_paused_clear: assert property (
    !ctl.task_paused |=> !status.std[BIT_PAUSED])
    else $error("paused stuck");
  a_estop_clear: assert property (
    !ctl.estop |=> !status.std[BIT_ESTOP])
    else $error("estop stuck");
  a_guard_level: assert property (
    1'b1 |=> status.std[BIT_GUARD] == $past(ctl.guard_open))
    else $error("guard level wrong");
  a_warn_follows: assert property (
    1'b1 |=> status.std[BIT_WARN] == $past(ctl.warn_active))
    else $error("warning flag wrong");

  // Latched faults and the remote reset input
  a_error_clear: assert property (
    (clear_req && !crit_reg && !ctl.error_event) |=> !error_reg)
    else $error("error not cleared");
  a_error_gated: assert property (
    (error_reg && !status.remote_accept_state) |=> error_reg)
    else $error("error cleared outside accept");
  a_crit_set: assert property (
    ctl.crit_event |=> crit_reg)
    else $error("critical not latched");
  a_crit_blocks: assert property (
    crit_reg |-> !reset_accepted)
    else $error("reset accepted on critical");
  a_accept_gate: assert property (
    !status.remote_accept_state |-> !reset_accepted)
    else $error("reset accepted outside accept");

  // Arm selection and the per-arm flags
  a_motor_off: assert property (
    !(|(arm.motor & arm_sel_reg)) |=> !status.motor_energized)
    else $error("motor flag stuck");
  a_home_select: assert property (
    1'b1 |=> status.home_position_flag == $past(|(arm.home & arm_sel_reg)))
    else $error("home flag wrong");
  a_power_select: assert property (
    1'b1 |=> status.high_power_flag
             == $past(|(arm.high_power & arm_sel_reg)))
    else $error("power flag wrong");
  a_calib_select: assert property (
    1'b1 |=> status.calibration_needed == $past(|(arm.uncal & arm_sel_reg)))
    else $error("calibration flag wrong");
  a_sel_empty: assert property (
    (sel_valid && sel_s3_reg == '0) |=> $stable(arm_sel_reg))
    else $error("empty selection taken");
  a_sel_load: assert property (
    (sel_valid && sel_s3_reg != '0) |=> arm_sel_reg == $past(sel_s3_reg))
    else $error("selection not loaded");

  // Plain followers, one edge behind the controller state
  a_recover_track: assert property (
    1'b1 |=> status.recover_pending == $past(ctl.recover_wait)
         && status.recover_active == $past(ctl.recover_run))
    else $error("recover flags wrong");
  a_cmd_track: assert property (
    1'b1 |=> status.command_executing == $past(ctl.cmd_busy)
         && status.command_rejected == $past(ctl.cmd_reject))
    else $error("command flags wrong");
  a_accept_track: assert property (
    1'b1 |=> status.remote_accept_state == $past(ctl.remote_ok))
    else $error("accept state wrong");
  a_mode_track: assert property (
    1'b1 |=> status.teach_state_flag == $past(ctl.teach)
         && status.test_state_flag == $past(ctl.test))
    else $error("mode flags wrong");
  a_enable_track: assert property (
    1'b1 |=> status.enable_switch_flag == $past(ctl.enable_sw))
    else $error("enable flag wrong");

  c_error_clear: cover property (
    status.std[BIT_ERROR] ##1 clear_req ##2 !status.std[BIT_ERROR]);
  c_crit_set: cover property (ctl.crit_event ##1 status.std[BIT_CRIT]);
  c_sel_refused: cover property (sel_rise && !status.remote_accept_state);
  c_sel_change: cover property (sel_valid ##1 $changed(arm_sel_reg));
  c_run_pause: cover property (
    status.std[BIT_RUNNING] ##[1:20] status.std[BIT_PAUSED]);

endmodule // rso_status_out
`default_nettype wire

// ### tb/rso_plc_model.sv
`default_nettype none
// ---------------------------------------------------------------
// External control device driving the remote input pins
// ---------------------------------------------------------------
module rso_plc_model (
  input wire logic clk,
  output logic reset_input_pin,
  output logic [rso_pkg::ARM_N-1:0] arm_select_pin,
  output logic arm_select_strobe_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  import rso_pkg::*;

  // Idle levels at time zero
  initial
  begin
    reset_input_pin = 1'b0;
    arm_select_pin = '0;
    arm_select_strobe_pin = 1'b0;
  end

  // Held well past the pin filter so the device cannot miss it
  task automatic pulse_reset();
    @(negedge clk);
    reset_input_pin = 1'b1;
    repeat (8) @(negedge clk);
    reset_input_pin = 1'b0;
  endtask

  // Selection set up first, strobed, then the lines are let go
  task automatic select(input logic [ARM_N-1:0] sel);
    @(negedge clk);
    arm_select_pin = sel;
    repeat (2) @(negedge clk);
    arm_select_strobe_pin = 1'b1;
    repeat (8) @(negedge clk);
    arm_select_strobe_pin = 1'b0;
    repeat (2) @(negedge clk);
    arm_select_pin = ~sel; // Released lines do not keep the value
  endtask
endmodule // rso_plc_model
`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import rso_pkg::*;

  // ---------------------------------------------------------------
  // Signals and model state
  // ---------------------------------------------------------------
  logic clk, rst, stb_pin, rin_pin, acc;
  logic [ARM_N-1:0] sel_pin, sel_m;
  rso_ctl_s ctl, b;
  rso_arm_s arm, a;
  rso_out_s status;
  rso_out_s exp_q[$];
  int fail_count, check_count, cyc;
  logic [31:0] seed;
  logic [63:0] rr;
  logic err_m, crit_m, up_m;

  rso_status_out #(.ARMS(ARM_N)) u_dut (.clk(clk), .rst(rst), .ctl(ctl),
    .arm(arm), .arm_select_pin(sel_pin), .arm_select_strobe_pin(stb_pin),
    .reset_input_pin(rin_pin), .reset_accepted(acc), .status(status));
  rso_plc_model u_plc (.clk(clk), .reset_input_pin(rin_pin),
    .arm_select_pin(sel_pin), .arm_select_strobe_pin(stb_pin));

  // Clock, 50 ns period
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk_status(input rso_out_s e);
    check_count++;
    if (status !== e)
    begin
      fail_count++;
      $display("[ERR] %0t status %h exp %h", $time, status, e);
    end
  endtask

  task automatic chk_accept(input logic e);
    check_count++;
    if (acc !== e)
    begin
      fail_count++;
      $display("[ERR] %0t reset accept %b exp %b", $time, acc, e);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Drive one state at the falling edge and note what must follow
  task automatic apply(input rso_ctl_s c, input rso_arm_s d);
    rso_out_s e;
    @(negedge clk);
    ctl = c;
    arm = d;
    e = '0;
    e.std[BIT_READY] = up_m & ~c.task_running;
    e.std[BIT_RUNNING] = c.task_running & ~c.task_paused;
    e.std[BIT_PAUSED] = c.task_paused;
    e.std[BIT_ERROR] = err_m;
    e.std[BIT_ESTOP] = c.estop;
    e.std[BIT_GUARD] = c.guard_open;
    e.std[BIT_CRIT] = crit_m;
    e.std[BIT_WARN] = c.warn_active;
    e.motor_energized = |(d.motor & sel_m);
    e.home_position_flag = |(d.home & sel_m);
    e.high_power_flag = |(d.high_power & sel_m);
    e.calibration_needed = |(d.uncal & sel_m);
    e.recover_pending = c.recover_wait;
    e.recover_active = c.recover_run;
    e.command_executing = c.cmd_busy;
    e.command_rejected = c.cmd_reject;
    e.function_number = c.func_num;
    e.remote_accept_state = c.remote_ok;
    e.teach_state_flag = c.teach;
    e.test_state_flag = c.test;
    e.enable_switch_flag = c.enable_sw;
    e.fault_number = c.fault_num;
    e.area_occupancy = c.area;
    // Latched flags show one edge after the event is sampled
    up_m = up_m | c.startup_done;
    err_m = err_m | c.error_event;
    crit_m = crit_m | c.crit_event;
    exp_q.push_back(e);
  endtask

  // Remote reset, honoured only while accepted and no critical error
  task automatic remote_clear();
    apply(b, a);
    u_plc.pulse_reset();
    chk_accept(b.remote_ok && !crit_m);
    repeat (4) @(negedge clk);
    chk_accept(1'b0);
    if (b.remote_ok && !crit_m)
      err_m = 1'b0;
    apply(b, a);
  endtask

  task automatic remote_sel(input logic [ARM_N-1:0] s);
    apply(b, a);
    u_plc.select(s);
    repeat (4) @(negedge clk);
    if (b.remote_ok && s != '0)
      sel_m = s;
    apply(b, a);
  endtask

  // Checker of results, one note per result
  initial
  forever
  begin
    @(posedge clk);
    #5;
    if (exp_q.size() > 0)
      chk_status(exp_q.pop_front());
  end

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      $display("[ERR] %0t run too long", $time);
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    ctl = '0;
    arm = '0;
    fail_count = 0;
    check_count = 0;
    cyc = 0;
    seed = 32'hd46c;
    {err_m, crit_m, up_m} = 3'b000;
    sel_m = ARM_SEL_RST;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    // Random states, errors kept rare so the latch is seen both ways
    for (int i = 0; i < 300; i++)
    begin
      seed = xs(seed);
      rr[63:32] = seed;
      seed = xs(seed);
      rr[31:0] = seed;
      b = rso_ctl_s'(rr[$bits(rso_ctl_s)-1:0]);
      b.error_event = b.error_event & rr[63] & rr[62] & rr[61];
      b.crit_event = 1'b0;
      seed = xs(seed);
      a = rso_arm_s'({seed, ~seed});
      apply(b, a);
    end
    $display("test random done");
    // Error latch against the remote reset input
    b.error_event = 1'b1;
    b.remote_ok = 1'b0;
    apply(b, a);
    b.error_event = 1'b0;
    remote_clear();
    b.remote_ok = 1'b1;
    remote_clear();
    b.error_event = 1'b1;
    b.crit_event = 1'b1;
    apply(b, a);
    b.error_event = 1'b0;
    b.crit_event = 1'b0;
    remote_clear();
    $display("test error latch done");
    // Arm selection: one arm, all-zero ignored, refused when not remote
    a = '0;
    a.motor = 16'h0002;
    a.home = 16'h0001;
    a.high_power = 16'h0002;
    a.uncal = 16'h8001;
    apply(b, a);
    remote_sel(16'h0001);
    remote_sel(16'h0000);
    b.remote_ok = 1'b0;
    remote_sel(16'h0002);
    $display("test selection done");
    // Reboot in mid-run clears the critical error and returns the selection to all arms
    @(negedge clk);
    rst = 1'b1;
    exp_q.push_back('0);
    @(negedge clk);
    {err_m, crit_m} = 2'b00;
    up_m = b.startup_done; // Still on ctl at the first edge out of reset
    sel_m = ARM_SEL_RST;
    @(negedge clk);
    rst = 1'b0;
    apply(b, a);
    repeat (3) @(negedge clk);
    $display("test reboot done");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
